// file: rtl/pqs_params.svh
// constants: register addresses, field positions, reset values, frame counts
`ifndef PQS_PARAMS_SVH
`define PQS_PARAMS_SVH

// ----------------------------------------------------------------
// management register addresses
// ----------------------------------------------------------------
`define PQS_ADDR_QSTAT   5'h11
`define PQS_ADDR_TOPS    5'h12

// ----------------------------------------------------------------
// quick status field positions
// ----------------------------------------------------------------
`define PQS_Q_LOCK       9
`define PQS_Q_EARLY      5
`define PQS_Q_ANCPL      4
`define PQS_Q_SIGDET     3
`define PQS_Q_JABBER     2
`define PQS_Q_RFAULT     1
`define PQS_Q_LINK       0

// ----------------------------------------------------------------
// operations register fields and reset value
// ----------------------------------------------------------------
`define PQS_T_RSV15      15
`define PQS_T_POLREV     14
`define PQS_T_CTRL_HI    5
`define PQS_TOPS_CTRL_RST 6'h10

// ----------------------------------------------------------------
// serial frame fields
// ----------------------------------------------------------------
`define PQS_PRE_MIN      6'h20
`define PQS_OP_READ      2'h2
`define PQS_OP_WRITE     2'h1
`define PQS_OP_LAST      5'h01
`define PQS_ADDR_LAST    5'h09
`define PQS_DATA_LAST    5'h0F

`endif

// file: rtl/pqs_pkg.sv
// types shared by the status and operations register block
package pqs_pkg;

  // serial management frame phases
  typedef enum logic [2:0] {
    PQS_PRE   = 3'h0,
    PQS_START = 3'h1,
    PQS_OP    = 3'h2,
    PQS_ADDR  = 3'h3,
    PQS_TA    = 3'h4,
    PQS_DATA  = 3'h5
  } pqs_state_type;

  // one-cycle receive error events from the 100 Mb/s receiver
  typedef struct packed {
    logic lock_err;
    logic false_carrier;
    logic bad_symbol;
    logic halt_symbol;
    logic early_end;
  } pqs_rx_evt_type;

  // operations register control bits, laid out as bits 5..0
  typedef struct packed {
    logic jabber_check_off;
    logic rsv_bit4;
    logic auto_pol_off;
    logic sqe_test_off;
    logic link_force_pass;
    logic squelch_idle_req;
  } pqs_ctrl_type;

endpackage : pqs_pkg

// file: rtl/pqs_regs.sv
// quick status and 10Base-T operations registers behind serial management
`include "pqs_params.svh"

module pqs_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    mdc_pin,
  input  wire logic                    mdio_in,
  output logic                         mdio_out,
  output logic                         mdio_oe_n,
  input  wire logic [4:0]              phy_addr,
  input  wire logic                    speed_100,
  input  wire pqs_pkg::pqs_rx_evt_type rx_evt,
  input  wire logic                    an_enable,
  input  wire logic                    an_done,
  input  wire logic                    signal_detect,
  input  wire logic                    jabber_evt,
  input  wire logic                    remote_fault_evt,
  input  wire logic                    link_up,
  input  wire logic                    polarity_rev,
  output pqs_pkg::pqs_ctrl_type        ctrl,
  output logic                         rx_err_out
);
  import pqs_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // phy and register address both match
  function automatic logic is_hit(input logic [9:0] a,
                                  input logic [4:0] phy,
                                  input logic [4:0] regad);
    is_hit = (a[9:5] == phy) && (a[4:0] == regad);
  endfunction : is_hit

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [1:0] pins_q;
  logic       mdc_q;
  logic       mdio_q;
  logic       mdc_d_reg;

  pqs_sync #(
    .W (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  ({mdc_pin, mdio_in}),
    .pin_q   (pins_q)
  );

  assign mdc_q  = pins_q[1];
  assign mdio_q = pins_q[0];

  // previous filtered clock level for the rising-edge detect
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mdc_d_reg <= 1'b0;
    end else begin
      mdc_d_reg <= mdc_q;
    end
  end

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  pqs_state_type st_reg;
  pqs_state_type st_next;
  logic [5:0]    pre_reg;
  logic [5:0]    pre_next;
  logic [4:0]    cnt_reg;
  logic [4:0]    cnt_next;
  logic [1:0]    op_reg;
  logic [1:0]    op_next;
  logic [9:0]    addr_reg;
  logic [9:0]    addr_next;
  logic [15:0]   sh_reg;
  logic [15:0]   sh_next;
  logic          rd_reg;
  logic          rd_next;
  logic          out_reg;
  logic          out_next;
  logic          oe_n_reg;
  logic          oe_n_next;

  // ----------------------------------------------------------------
  // status and control storage
  // ----------------------------------------------------------------
  logic [4:0]    lh17_reg;
  logic [4:0]    lh17_next;
  logic          jab_reg;
  logic          rf_reg;
  logic          link_ll_reg;
  logic          pol_reg;
  pqs_ctrl_type  ctrl_reg;
  logic          rx_err_reg;

  // ----------------------------------------------------------------
  // decode and read data
  // ----------------------------------------------------------------
  logic          mdc_rise;
  logic [9:0]    addr_full;
  logic          addr_done;
  logic          rd_take;
  logic          clr17;
  logic          clr18;
  logic          wr_take;
  logic [15:0]   wdata;
  logic [4:0]    set17;
  logic          an_cpl;
  logic [15:0]   q17_word;
  logic [15:0]   t18_word;
  logic [15:0]   rd_word;

  assign mdc_rise  = mdc_q & ~mdc_d_reg;
  assign addr_full = {addr_reg[8:0], mdio_q};
  assign addr_done = mdc_rise && (st_reg == PQS_ADDR)
                     && (cnt_reg == `PQS_ADDR_LAST);
  assign rd_take   = addr_done && (op_reg == `PQS_OP_READ)
                     && (addr_full[9:5] == phy_addr);
  // a read of a latching register clears it at the moment it is sampled
  assign clr17     = rd_take && is_hit(addr_full, phy_addr, `PQS_ADDR_QSTAT);
  assign clr18     = rd_take && is_hit(addr_full, phy_addr, `PQS_ADDR_TOPS);
  assign wdata     = {sh_reg[14:0], mdio_q};
  assign wr_take   = mdc_rise && (st_reg == PQS_DATA) && !rd_reg
                     && (cnt_reg == `PQS_DATA_LAST)
                     && (op_reg == `PQS_OP_WRITE)
                     && is_hit(addr_reg, phy_addr, `PQS_ADDR_TOPS);

  // receive events only count at 100 Mb/s; at 10 they read zero
  assign set17 = {5{speed_100}} & {rx_evt.lock_err,
                                   rx_evt.false_carrier,
                                   rx_evt.bad_symbol,
                                   rx_evt.halt_symbol,
                                   rx_evt.early_end};

  // completion is masked while negotiation is disabled
  assign an_cpl = an_enable & an_done;

  // upper status fields are not held here and read zero
  assign q17_word = {6'h00, lh17_reg, an_cpl,
                     signal_detect,
                     jab_reg, rf_reg, link_ll_reg};
  // reserved 15 and 13..6 read zero
  assign t18_word = {1'b0, pol_reg, 8'h00, ctrl_reg};

  // unmapped addresses answer with zeros
  assign rd_word = (addr_full[4:0] == `PQS_ADDR_QSTAT) ? q17_word :
                   (addr_full[4:0] == `PQS_ADDR_TOPS)  ? t18_word :
                   16'h0000;

  // ----------------------------------------------------------------
  // frame sequencer: preamble, start, op, addresses, turnaround, data
  // ----------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    op_next   = op_reg;
    addr_next = addr_reg;
    sh_next   = sh_reg;
    rd_next   = rd_reg;
    out_next  = out_reg;
    oe_n_next = oe_n_reg;
    if (mdc_rise) begin
      case (st_reg)
        PQS_PRE: begin
          if (mdio_q) begin
            if (pre_reg != `PQS_PRE_MIN) begin
              pre_next = pre_reg + 6'h01;
            end
          end else if (pre_reg == `PQS_PRE_MIN) begin
            st_next  = PQS_START;
            pre_next = 6'h00;
          end else begin
            pre_next = 6'h00;
          end
        end
        PQS_START: begin
          cnt_next = 5'h00;
          st_next  = mdio_q ? PQS_OP : PQS_PRE;
        end
        PQS_OP: begin
          op_next = {op_reg[0], mdio_q};
          if (cnt_reg == `PQS_OP_LAST) begin
            st_next  = PQS_ADDR;
            cnt_next = 5'h00;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
        PQS_ADDR: begin
          addr_next = addr_full;
          if (cnt_reg == `PQS_ADDR_LAST) begin
            st_next  = PQS_TA;
            cnt_next = 5'h00;
            rd_next  = rd_take;
            sh_next  = rd_word;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
        PQS_TA: begin
          if (cnt_reg == 5'h00) begin
            // second turnaround bit is driven low on a read
            cnt_next = 5'h01;
            if (rd_reg) begin
              oe_n_next = 1'b0;
              out_next  = 1'b0;
            end
          end else begin
            st_next  = PQS_DATA;
            cnt_next = 5'h00;
            if (rd_reg) begin
              out_next = sh_reg[15];
              sh_next  = {sh_reg[14:0], 1'b0};
            end
          end
        end
        PQS_DATA: begin
          if (rd_reg) begin
            out_next = sh_reg[15];
            sh_next  = {sh_reg[14:0], 1'b0};
          end else begin
            sh_next = wdata;
          end
          if (cnt_reg == `PQS_DATA_LAST) begin
            // every frame needs a fresh preamble; no suppression
            st_next   = PQS_PRE;
            pre_next  = 6'h00;
            rd_next   = 1'b0;
            oe_n_next = 1'b1;
            out_next  = 1'b0;
          end else begin
            cnt_next = cnt_reg + 5'h01;
          end
        end
        default: begin
          st_next   = PQS_PRE;
          pre_next  = 6'h00;
          rd_next   = 1'b0;
          oe_n_next = 1'b1;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg   <= PQS_PRE;
      pre_reg  <= 6'h00;
      cnt_reg  <= 5'h00;
      op_reg   <= 2'h0;
      addr_reg <= 10'h000;
      sh_reg   <= 16'h0000;
      rd_reg   <= 1'b0;
      out_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      st_reg   <= st_next;
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      op_reg   <= op_next;
      addr_reg <= addr_next;
      sh_reg   <= sh_next;
      rd_reg   <= rd_next;
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign mdio_out  = out_reg;
  assign mdio_oe_n = oe_n_reg;

  // ----------------------------------------------------------------
  // latching status bits
  // ----------------------------------------------------------------
  // set beats clear so an event in the read cycle is never lost
  assign lh17_next = (lh17_reg & ~{5{clr17}}) | set17;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lh17_reg    <= 5'h00;
      jab_reg     <= 1'b0;
      rf_reg      <= 1'b0;
      link_ll_reg <= 1'b0;
      pol_reg     <= 1'b0;
    end else begin
      lh17_reg    <= lh17_next;
      jab_reg     <= (jab_reg & ~clr17) | jabber_evt;
      rf_reg      <= (rf_reg & ~clr17) | remote_fault_evt;
      // a read reloads the live level; any drop holds zero
      link_ll_reg <= clr17 ? link_up : (link_ll_reg & link_up);
      pol_reg     <= (pol_reg & ~clr18) | polarity_rev;
    end
  end

  // ----------------------------------------------------------------
  // operations controls and error report to the MAC
  // ----------------------------------------------------------------
  // only bits 5..0 are stored; the station keeps bit 4 at one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= `PQS_TOPS_CTRL_RST;
      rx_err_reg <= 1'b0;
    end else begin
      if (wr_take) begin
        ctrl_reg <= wdata[`PQS_T_CTRL_HI:0];
      end
      rx_err_reg <= speed_100 & (rx_evt.bad_symbol | rx_evt.halt_symbol
                                 | rx_evt.early_end);
    end
  end

  assign ctrl       = ctrl_reg;
  assign rx_err_out = rx_err_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_lock_latch: assert property (
    speed_100 && rx_evt.lock_err |=> q17_word[`PQS_Q_LOCK] [*1])
    else $error("lock error flag not set");
  chk_read_clear: assert property (
    clr17 && !set17[4] |=> !q17_word[`PQS_Q_LOCK])
    else $error("lock error flag not cleared by read");
  chk_flag_hold: assert property (
    lh17_reg[3] && !clr17 |=> lh17_reg[3])
    else $error("false carrier flag dropped without read");
  chk_set_wins: assert property (
    clr17 && set17[2] |=> lh17_reg[2])
    else $error("event in read cycle was lost");
  chk_err_report: assert property (
    speed_100 && (rx_evt.halt_symbol || rx_evt.early_end)
    |=> rx_err_out && (lh17_reg[1] || lh17_reg[0]))
    else $error("symbol error not reported");
  chk_ten_quiet: assert property (
    !speed_100 && lh17_reg == 5'h00 && !clr17 |=> lh17_reg == 5'h00)
    else $error("receive flag set at 10 Mb/s");
  chk_an_done: assert property (
    q17_word[`PQS_Q_ANCPL] == (an_enable && an_done))
    else $error("negotiation complete shown while disabled");
  chk_link_low: assert property (
    (!link_up || !link_ll_reg) && !clr17 |=> !q17_word[`PQS_Q_LINK])
    else $error("link drop not latched low");
  chk_jab_mirror: assert property (
    jabber_evt || remote_fault_evt |=>
    (q17_word[`PQS_Q_JABBER] || !$past(jabber_evt))
    && (q17_word[`PQS_Q_RFAULT] || !$past(remote_fault_evt)))
    else $error("jabber or remote fault not reflected");
  chk_rsv_read: assert property (
    clr18 |=> !sh_reg[`PQS_T_RSV15] && sh_reg[5:0] == $past(ctrl_reg))
    else $error("operations register read data wrong");
  chk_ctrl_write: assert property (
    wr_take |=> ctrl_reg == $past(wdata[5:0]))
    else $error("operations control write lost");
  chk_pol_flag: assert property (
    polarity_rev |=> t18_word[`PQS_T_POLREV])
    else $error("polarity reversal not reported");
  chk_drive_read: assert property (
    !mdio_oe_n |-> rd_reg)
    else $error("data line driven outside a read");

  cov_read_status: cover property (clr17 && lh17_reg != 5'h00);
  cov_write_ops:   cover property (wr_take);
  cov_read_ops:    cover property (clr18 ##[1:300] !mdio_oe_n);
  cov_link_drop:   cover property (link_ll_reg ##1 !link_ll_reg);

endmodule : pqs_regs

// file: rtl/pqs_sync.sv
// three-stage pin synchroniser with agreement filter
module pqs_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_q
);

  // ----------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      // first stage feeds only the second; a change counts once 2 and 3 agree
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_reg  <= 1'b0;
        end else begin
          s1_reg <= pin_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
      assign pin_q[gi] = q_reg;
    end
  endgenerate

endmodule : pqs_sync

// file: test/pqs_station.sv
// station management model that drives frames on the management pins
module pqs_station (
  input  wire logic clk_sys,
  output logic      mdc,
  output logic      sta_drive,
  output logic      sta_oe,
  input  wire logic mdio_wire
);
  timeunit 1ns;
  timeprecision 100ps;

  // mdc half period in clk_sys cycles; the bench slows it for some frames
  int half_per;

  // mdc stands low and the line is released between frames
  initial begin
    half_per = 8;
    mdc = 1'h0;
    sta_drive = 1'h0;
    sta_oe = 1'h0;
  end

  // change the line while mdc is low, sample just before the rise
  task automatic bit_cycle(input logic d, input logic drv, output logic s);
    @(posedge clk_sys) #1;
    mdc = 1'h0;
    sta_oe = drv;
    sta_drive = d;
    repeat (half_per) @(posedge clk_sys);
    #1;
    s = mdio_wire;
    mdc = 1'h1;
    repeat (half_per - 1) @(posedge clk_sys);
  endtask : bit_cycle

  // one whole frame; on reads the line is released from turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [45:0] hdr;
    logic        wr;
    logic        s;
    hdr = {32'hFFFFFFFF, 2'h1, op, pa, ra}; // full preamble every frame
    wr = (op == 2'h1);
    for (int i = 45; i >= 0; i--) bit_cycle(hdr[i], 1'h1, s);
    bit_cycle(1'h1, wr, s);
    bit_cycle(1'h0, wr, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(wd[i], wr, s);
      rd[i] = s;
    end
    @(posedge clk_sys) #1;
    mdc = 1'h0;
    sta_oe = 1'h0;
    repeat (2 * half_per) @(posedge clk_sys);
    #1; // callers then change inputs off the edge, never on it
  endtask : frame
endmodule : pqs_station

// file: test/test_pqs_regs.sv
// self-checking bench for the quick status and operations registers
`include "pqs_params.svh"
`define CHK(nm, ex, gt) begin checks++; if ((ex) !== (gt)) begin \
  mismatches++; $display("Error %s expected %0h seen %0h", nm, ex, gt); \
  end end

module test_pqs_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import pqs_pkg::*;

  logic           clk_sys, rst, mdc_pin, mdio_in, mdio_out, mdio_oe_n;
  logic [4:0]     phy_addr;
  logic           speed_100, an_enable, an_done, signal_detect;
  logic           jabber_evt, remote_fault_evt, link_up, polarity_rev;
  logic           rx_err_out, sta_drive, sta_oe, oe_seen;
  pqs_rx_evt_type rx_evt;
  pqs_ctrl_type   ctrl;
  logic [15:0]    lfsr, rd, wd;
  int             mismatches, checks, lh, link_m, ctrl_m, pol_m;

  // the line has a pull-up; the device wins over the station
  assign mdio_in = !mdio_oe_n ? mdio_out : (sta_oe ? sta_drive : 1'h1);

  pqs_regs dut (.clk_sys(clk_sys), .rst(rst), .mdc_pin(mdc_pin),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .phy_addr(phy_addr), .speed_100(speed_100), .rx_evt(rx_evt),
    .an_enable(an_enable), .an_done(an_done),
    .signal_detect(signal_detect), .jabber_evt(jabber_evt),
    .remote_fault_evt(remote_fault_evt), .link_up(link_up),
    .polarity_rev(polarity_rev), .ctrl(ctrl), .rx_err_out(rx_err_out));

  pqs_station sta (.clk_sys(clk_sys), .mdc(mdc_pin), .sta_drive(sta_drive),
    .sta_oe(sta_oe), .mdio_wire(mdio_in));

  // clock generator
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end

  // notes any cycle in which the device drives the line
  always @(posedge clk_sys) if (mdio_oe_n === 1'h0) oe_seen <= 1'h1;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // event bits that are present right now, placed as in quick status
  function automatic int live();
    return (speed_100 ? int'({rx_evt, 5'h00}) : 0) |
           (jabber_evt << 2) | (remote_fault_evt << 1);
  endfunction : live

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // read quick status and compare with the model, then apply the clear
  task automatic rd_qs();
    int exp;
    lh = lh | live();
    if (!link_up) link_m = 0;
    exp = lh | ((an_enable && an_done) << 4) | (signal_detect << 3) | link_m;
    sta.frame(`PQS_OP_READ, phy_addr, `PQS_ADDR_QSTAT, 16'h0000, rd);
    `CHK("quick_status", exp, rd)
    lh = live();
    link_m = link_up;
  endtask : rd_qs

  // read the operations register; reserved bits read zero
  task automatic rd_ops();
    int exp;
    exp = ((pol_m | polarity_rev) << 14) | ctrl_m;
    sta.frame(`PQS_OP_READ, phy_addr, `PQS_ADDR_TOPS, 16'h0000, rd);
    `CHK("tenbase_operations", exp, rd)
    pol_m = polarity_rev;
  endtask : rd_ops

  task automatic wr_ops(input logic [15:0] d);
    sta.frame(`PQS_OP_WRITE, phy_addr, `PQS_ADDR_TOPS, d, rd);
    ctrl_m = d[5:0];
    repeat (4) @(posedge clk_sys);
    `CHK("ctrl", ctrl_m, ctrl)
    rd_ops();
  endtask : wr_ops

  // one-cycle receive event; the error to the mac follows one cycle later
  task automatic pulse_rx(input int i);
    @(posedge clk_sys) #1;
    rx_evt = pqs_rx_evt_type'(5'h01 << i);
    @(posedge clk_sys) #1;
    rx_evt = '0;
    `CHK("rx_err_out", speed_100 && i <= 2, rx_err_out)
    if (speed_100) lh = lh | (1 << (5 + i));
  endtask : pulse_rx

  task automatic reset_dut();
    rst = 1'h1;
    repeat (4) @(posedge clk_sys);
    #1 rst = 1'h0;
    lh = 0;
    link_m = 0;
    pol_m = 0;
    ctrl_m = 16;
    repeat (4) @(posedge clk_sys);
    `CHK("ctrl", 6'h10, ctrl)
    `CHK("mdio_oe_n", 1'h1, mdio_oe_n)
  endtask : reset_dut

  // a hung handshake ends the run through the same closing task
  initial begin
    repeat (80000) @(posedge clk_sys);
    mismatches++;
    $display("watchdog expired");
    conclude();
  end

  // main sequence
  initial begin
    {rst, speed_100, an_enable, an_done, signal_detect} = 5'h10;
    {jabber_evt, remote_fault_evt, link_up, polarity_rev} = 4'h0;
    rx_evt = '0;
    phy_addr = 5'h00;
    oe_seen = 1'h0;
    mismatches = 0;
    checks = 0;
    lfsr = 16'h002C;
    reset_dut();
    phy_addr = lfsr[4:0];
    rd_ops();
    rd_qs();
    $display("test reset values done");
    for (int i = 0; i < 5; i++) pulse_rx(i);
    rd_qs();
    speed_100 = 1'h1;
    for (int i = 0; i < 5; i++) begin
      pulse_rx(i);
      rd_qs();
      rd_qs();
    end
    $display("test receive events done");
    rx_evt.bad_symbol = 1'h1;
    repeat (3) @(posedge clk_sys);
    `CHK("rx_err_out", 1'h1, rx_err_out)
    rd_qs();
    rd_qs();
    rx_evt = '0;
    rd_qs();
    rd_qs();
    $display("test held event done");
    for (int k = 0; k < 4; k++) begin
      {an_enable, an_done} = k[1:0];
      signal_detect = k[0] ^ k[1];
      link_up = k[1];
      jabber_evt = (k == 1);
      remote_fault_evt = (k == 2);
      repeat (2) @(posedge clk_sys) #1;
      lh = lh | live(); // the pulses latch into 17.2 and 17.1
      {jabber_evt, remote_fault_evt} = 2'h0;
      rd_qs();
    end
    @(posedge clk_sys) #1 link_up = 1'h0;
    @(posedge clk_sys) #1 link_up = 1'h1;
    link_m = 0;
    rd_qs();
    rd_qs();
    $display("test status mirrors done");
    @(posedge clk_sys) #1 polarity_rev = 1'h1;
    @(posedge clk_sys) #1 polarity_rev = 1'h0;
    pol_m = 1;
    rd_ops();
    rd_ops();
    sta.half_per = 12;
    for (int w = 0; w < 4; w++) begin
      lfsr = lfsr_next(lfsr);
      wd = {10'h000, lfsr[5], 1'h1, lfsr[3:0]};
      if (w < 2) wd = w ? 16'h0010 : 16'h003F;
      wr_ops(wd);
    end
    sta.half_per = 8;
    $display("test operations writes done");
    @(posedge clk_sys) #1 jabber_evt = 1'h1;
    @(posedge clk_sys) #1 jabber_evt = 1'h0;
    lh = lh | 4;
    oe_seen = 1'h0;
    sta.frame(`PQS_OP_READ, phy_addr ^ 5'h01, `PQS_ADDR_QSTAT, 16'h0, rd);
    `CHK("foreign read", 16'hFFFF, rd)
    `CHK("foreign drive", 1'h0, oe_seen)
    sta.frame(`PQS_OP_WRITE, phy_addr ^ 5'h10, `PQS_ADDR_TOPS, 16'h0030, rd);
    sta.frame(`PQS_OP_WRITE, phy_addr, `PQS_ADDR_QSTAT, 16'hFFFF, rd);
    sta.frame(`PQS_OP_READ, phy_addr, 5'h13, 16'h0, rd);
    `CHK("unmapped read", 16'h0000, rd)
    rd_ops();
    rd_qs();
    $display("test refused frames done");
    wr_ops(16'h0030);
    reset_dut();
    rd_ops();
    $display("test second reset done");
    conclude();
  end
endmodule : test_pqs_regs
